// file: ppg_pkg.sv
/*
 * Constants of the peripheral power gating block: register offsets,
 * field positions, reset values and bus widths.
 * Assumes a 12-bit byte address on an APB bus with 32-bit data.
 */
package ppg_pkg;

	////////////////////////////////////////////////////////////////////////
	// Bus geometry
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 32;

	////////////////////////////////////////////////////////////////////////
	// Register offsets (byte addresses)
	localparam logic [11:0] OFF_POWER_GATE = 12'hf80;
	localparam logic [11:0] OFF_GATE_STATUS = 12'hf84;

	////////////////////////////////////////////////////////////////////////
	// Fields of the power gate register
	localparam int unsigned BIT_LOWPOWER_AMP_OFF = 7;
	localparam int unsigned BIT_BROWNOUT_DETECTOR_OFF = 4;
	localparam int unsigned BIT_TEMP_SENSOR_OFF = 3;
	localparam int unsigned BIT_CONVERTER_OFF = 2;
	localparam int unsigned BIT_COMPARATOR_OFF = 1;
	localparam logic [7:0] POWER_GATE_RESET = 8'h80;

	////////////////////////////////////////////////////////////////////////
	// Fields of the status register
	localparam int unsigned STAT_ENABLE_LSB = 0;
	localparam int unsigned STAT_AO_OPTION = 5;
	localparam int unsigned STAT_STOP_MODE = 6;

	////////////////////////////////////////////////////////////////////////
	// Gated peripherals, index order of the enable vector
	localparam int unsigned NUM_PERIPH = 5;
	localparam int unsigned IDX_COMPARATOR = 0;
	localparam int unsigned IDX_CONVERTER = 1;
	localparam int unsigned IDX_TEMP_SENSOR = 2;
	localparam int unsigned IDX_BROWNOUT = 3;
	localparam int unsigned IDX_LOWPOWER_AMP = 4;
	localparam logic [4:0] ENABLE_RESET = 5'h00;

endpackage

// file: ppg_gate_cell.sv
/*
 * One peripheral enable cell: a flop that enables the peripheral when
 * its disable bit is clear and its qualifier allows it.
 * Assumes the disable bit comes from a register in the same clock domain.
 */
module ppg_gate_cell
#(
	parameter logic RESET_EN = 1'b0
)
(
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	input  wire logic disable_i,
	input  wire logic qualify_i,
	output      logic enable_o
);

	// Enable follows the control bit one cycle later
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			enable_o <= RESET_EN;
		else
			enable_o <= !disable_i && qualify_i;
	end

endmodule

// file: ppg_top.sv
/*
 * Peripheral power gating: one 8-bit control register on APB that
 * disables the low-power amplifier, brown-out detector, temperature
 * sensor, converter and comparator, plus a read-only status word.
 * Assumes RST_N_I is the power-on reset; SYS_RST_N_I carries all other
 * system reset sources and is synchronous to SYS_CLK_I.
 */

module ppg_top
(
	input  wire logic        SYS_CLK_I,
	input  wire logic        RST_N_I,
	input  wire logic        SYS_RST_N_I,
	input  wire logic        PSEL_I,
	input  wire logic        PENABLE_I,
	input  wire logic        PWRITE_I,
	input  wire logic [11:0] PADDR_I,
	input  wire logic [31:0] PWDATA_I,
	input  wire logic [3:0]  PSTRB_I,
	input  wire logic        STOP_MODE_I,
	input  wire logic        BROWNOUT_AO_OPTION_I,
	output      logic        PREADY_O,
	output      logic [31:0] PRDATA_O,
	output      logic        PSLVERR_O,
	output      logic        LPAMP_EN_O,
	output      logic        BROWNOUT_EN_O,
	output      logic        TEMP_EN_O,
	output      logic        ADC_EN_O,
	output      logic        COMP_EN_O
);

	////////////////////////////////////////////////////////////////////////
	// Declarations
	logic [7:0]                      power_gate_q;
	logic                            pready_q;
	logic                            pslverr_q;
	logic [31:0]                     prdata_q;
	logic                            setup_phase;
	logic                            access_fire;
	logic                            write_fire;
	logic [ppg_pkg::NUM_PERIPH-1:0]  disable_vec;
	logic [ppg_pkg::NUM_PERIPH-1:0]  qualify_vec;
	logic [ppg_pkg::NUM_PERIPH-1:0]  enable_vec;
	logic [7:0]                      status_byte;
	logic [31:0]                     read_word;

	// Address match against one register offset
	function automatic logic ppg_hit(input logic [11:0] addr,
		input logic [11:0] off);
		ppg_hit = (addr == off);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// APB phase decode
	assign setup_phase = PSEL_I && !PENABLE_I;
	assign access_fire = PSEL_I && PENABLE_I && pready_q;
	assign write_fire  = access_fire && PWRITE_I && PSTRB_I[0] &&
		ppg_hit(PADDR_I, ppg_pkg::OFF_POWER_GATE);

	// Ready one cycle after setup; other resets abort a transfer
	always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
			pready_q <= 1'b0;
		else if (!SYS_RST_N_I)
			pready_q <= 1'b0;
		else
			pready_q <= setup_phase;
	end

	// Error for any address outside the two registers
	always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
			pslverr_q <= 1'b0;
		else if (!SYS_RST_N_I)
			pslverr_q <= 1'b0;
		else
			pslverr_q <= setup_phase &&
				!ppg_hit(PADDR_I, ppg_pkg::OFF_POWER_GATE) &&
				!ppg_hit(PADDR_I, ppg_pkg::OFF_GATE_STATUS);
	end

	////////////////////////////////////////////////////////////////////////
	// Read path
	assign status_byte = {1'b0, STOP_MODE_I, BROWNOUT_AO_OPTION_I,
		enable_vec};

	// Read mux, all eight stored bits returned
	always_comb
	begin
		read_word = 32'h0000_0000;
		if (ppg_hit(PADDR_I, ppg_pkg::OFF_POWER_GATE))
			read_word = {24'h00_0000, power_gate_q};
		else if (ppg_hit(PADDR_I, ppg_pkg::OFF_GATE_STATUS))
			read_word = {24'h00_0000, status_byte};
	end

	// Read data captured in setup, held through access
	always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
			prdata_q <= 32'h0000_0000;
		else if (!SYS_RST_N_I)
			prdata_q <= 32'h0000_0000;
		else if (setup_phase)
			prdata_q <= PWRITE_I ? 32'h0000_0000 : read_word;
	end

	////////////////////////////////////////////////////////////////////////
	// Power gate register, set to 8'h80 by power-on reset only
	always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
			power_gate_q <= ppg_pkg::POWER_GATE_RESET;
		else if (write_fire)
			power_gate_q <= PWDATA_I[7:0];
	end

	////////////////////////////////////////////////////////////////////////
	// Per-peripheral enable cells
	assign disable_vec[ppg_pkg::IDX_COMPARATOR] =
		power_gate_q[ppg_pkg::BIT_COMPARATOR_OFF];
	assign disable_vec[ppg_pkg::IDX_CONVERTER] =
		power_gate_q[ppg_pkg::BIT_CONVERTER_OFF];
	assign disable_vec[ppg_pkg::IDX_TEMP_SENSOR] =
		power_gate_q[ppg_pkg::BIT_TEMP_SENSOR_OFF];
	assign disable_vec[ppg_pkg::IDX_BROWNOUT] =
		power_gate_q[ppg_pkg::BIT_BROWNOUT_DETECTOR_OFF];
	assign disable_vec[ppg_pkg::IDX_LOWPOWER_AMP] =
		power_gate_q[ppg_pkg::BIT_LOWPOWER_AMP_OFF];

	// Only the brown-out detector needs the always-on option
	always_comb
	begin
		qualify_vec = {ppg_pkg::NUM_PERIPH{1'b1}};
		qualify_vec[ppg_pkg::IDX_BROWNOUT] = BROWNOUT_AO_OPTION_I;
	end

	// Enables ignore STOP_MODE_I, so the amplifier stays on in STOP
	generate
		for (genvar i = 0; i < ppg_pkg::NUM_PERIPH; i++)
		begin : g_cell
			ppg_gate_cell
			#(
				.RESET_EN (ppg_pkg::ENABLE_RESET[i])
			)
			u_cell
			(
				.clk_i     (SYS_CLK_I),
				.rst_n_i   (RST_N_I),
				.disable_i (disable_vec[i]),
				.qualify_i (qualify_vec[i]),
				.enable_o  (enable_vec[i])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Outputs
	assign PREADY_O      = pready_q;
	assign PSLVERR_O     = pslverr_q;
	assign PRDATA_O      = prdata_q;
	assign COMP_EN_O     = enable_vec[ppg_pkg::IDX_COMPARATOR];
	assign ADC_EN_O      = enable_vec[ppg_pkg::IDX_CONVERTER];
	assign TEMP_EN_O     = enable_vec[ppg_pkg::IDX_TEMP_SENSOR];
	assign BROWNOUT_EN_O = enable_vec[ppg_pkg::IDX_BROWNOUT];
	assign LPAMP_EN_O    = enable_vec[ppg_pkg::IDX_LOWPOWER_AMP];

	////////////////////////////////////////////////////////////////////////
	// Checks
	logic first_q;

	// Marks the first clock edge after power-on reset
	always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
			first_q <= 1'b1;
		else
			first_q <= 1'b0;
	end

	// Power-on value holds until the first edge
	chk_por_value: assert property (
		@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		first_q |-> power_gate_q == ppg_pkg::POWER_GATE_RESET &&
		!LPAMP_EN_O)
		else $error("power gate register not at power-on value");

	// Other resets leave the register alone
	chk_sysrst_keep: assert property (
		@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		!SYS_RST_N_I ##1 !SYS_RST_N_I |-> $stable(power_gate_q))
		else $error("register changed under system reset");

	// Write lands the whole byte at the next edge
	chk_write_byte: assert property (
		@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		write_fire |=> power_gate_q == $past(PWDATA_I[7:0]))
		else $error("write did not store whole byte");

	// Read returns all stored bits in the access phase
	chk_read_back: assert property (
		@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		setup_phase && !PWRITE_I && SYS_RST_N_I &&
		ppg_hit(PADDR_I, ppg_pkg::OFF_POWER_GATE)
		|=> PREADY_O && PRDATA_O == {24'h00_0000, $past(power_gate_q)})
		else $error("read data mismatch");

	// Analog peripherals follow their disable bits
	chk_analog_gate: assert property (
		@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		!first_q |-> {TEMP_EN_O, ADC_EN_O, COMP_EN_O} ==
		~$past({power_gate_q[ppg_pkg::BIT_TEMP_SENSOR_OFF],
		power_gate_q[ppg_pkg::BIT_CONVERTER_OFF],
		power_gate_q[ppg_pkg::BIT_COMPARATOR_OFF]}))
		else $error("analog enable mismatch");

	// Amplifier stays on through STOP when bit clear
	chk_amp_stop: assert property (
		@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		STOP_MODE_I && !power_gate_q[ppg_pkg::BIT_LOWPOWER_AMP_OFF]
		|=> LPAMP_EN_O)
		else $error("amplifier dropped in stop mode");

	// Brown-out needs both the bit and the option
	chk_brownout_and: assert property (
		@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		!first_q |-> BROWNOUT_EN_O ==
		(!$past(power_gate_q[ppg_pkg::BIT_BROWNOUT_DETECTOR_OFF]) &&
		$past(BROWNOUT_AO_OPTION_I)))
		else $error("brown-out enable mismatch");

	// Main scenarios
	cov_amp_on: cover property (
		@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		write_fire && !PWDATA_I[7] ##1 LPAMP_EN_O);
	cov_unmapped: cover property (
		@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		PSLVERR_O && PREADY_O);
	cov_sysrst: cover property (
		@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		!SYS_RST_N_I && !power_gate_q[ppg_pkg::BIT_LOWPOWER_AMP_OFF]);

endmodule

// file: test_peripheral_power_gating.sv
/*
 * Testbench of the peripheral power gating block: APB tasks and directed
 * sequences that compare register and enable outputs with expectations.
 * Assumes the block answers APB with pready and has one clock.
 */
module test_peripheral_power_gating;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [11:0] GATE = ppg_pkg::OFF_POWER_GATE;
	localparam logic [11:0] STAT = ppg_pkg::OFF_GATE_STATUS;

	logic        clk;
	logic        rst_n;
	logic        sys_rst_n;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [3:0]  pstrb;
	logic        stop_mode;
	logic        ao_opt;
	logic        pready;
	logic [31:0] prdata;
	logic        pslverr;
	wire  [4:0]  en;
	logic [31:0] rd;
	logic        err;
	int          n_errors;
	int          n_tests;
	logic [7:0]  pats [7] = '{8'h00, 8'h80, 8'h10, 8'h08, 8'h04, 8'h02, 8'h9e};

	////////////////////////////////////////////////////////////////////////
	// Clock of 4 ns
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	ppg_top dut (
		.SYS_CLK_I           (clk),
		.RST_N_I             (rst_n),
		.SYS_RST_N_I         (sys_rst_n),
		.PSEL_I              (psel),
		.PENABLE_I           (penable),
		.PWRITE_I            (pwrite),
		.PADDR_I             (paddr),
		.PWDATA_I            (pwdata),
		.PSTRB_I             (pstrb),
		.STOP_MODE_I         (stop_mode),
		.BROWNOUT_AO_OPTION_I(ao_opt),
		.PREADY_O            (pready),
		.PRDATA_O            (prdata),
		.PSLVERR_O           (pslverr),
		.LPAMP_EN_O          (en[4]),
		.BROWNOUT_EN_O       (en[3]),
		.TEMP_EN_O           (en[2]),
		.ADC_EN_O            (en[1]),
		.COMP_EN_O           (en[0])
	);

	////////////////////////////////////////////////////////////////////////
	// Compare, count, report
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			n_errors++;
			$display("MISMATCH at %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic give_verdict();
		if (n_errors == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// One APB transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Enables expected two edges after a write: set bit means off
	task automatic check_en(input logic [7:0] r);
		repeat (2) @(posedge clk);
		#1;
		check({27'h0, en}, {27'h0, ~r[7], ~r[4] & ao_opt, ~r[3:1]});
	endtask

	////////////////////////////////////////////////////////////////////////
	// Watchdog
	initial
	begin
		#20000;
		n_errors++;
		give_verdict();
	end

	// Main sequence
	initial
	begin
		{psel, penable, pwrite, paddr, pwdata, stop_mode} = '0;
		pstrb = 4'hf;
		rst_n = 1'b0;
		sys_rst_n = 1'b1;
		ao_opt = 1'b1;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		apb(1'b0, GATE, 32'h0);
		check(rd, 32'h80);
		check_en(8'h80);
		stop_mode <= 1'b1;
		foreach (pats[i])
		begin
			apb(1'b1, GATE, {24'h0, pats[i]});
			apb(1'b0, GATE, 32'h0);
			check(rd, {24'h0, pats[i]});
			check_en(pats[i]);
		end
		ao_opt <= 1'b0;
		apb(1'b1, GATE, 32'h0);
		check_en(8'h00);
		// Status word: STOP, option, then the five enables
		apb(1'b0, STAT, 32'h0);
		check(rd, 32'h57);
		// Write without lane 0 and write to status both ignored
		pstrb <= 4'h0;
		apb(1'b1, GATE, 32'h9e);
		pstrb <= 4'hf;
		apb(1'b1, STAT, 32'hff);
		check({31'h0, err}, 32'h0);
		apb(1'b0, GATE, 32'h0);
		check(rd, 32'h0);
		apb(1'b1, GATE, 32'h1234_5618);
		apb(1'b0, GATE, 32'h0);
		check(rd, 32'h18);
		apb(1'b1, 12'hf88, 32'h0);
		check({31'h0, err}, 32'h1);
		sys_rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		sys_rst_n <= 1'b1;
		apb(1'b0, GATE, 32'h0);
		check(rd, 32'h18);
		check_en(8'h18);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		apb(1'b0, GATE, 32'h0);
		check(rd, 32'h80);
		check_en(8'h80);
		give_verdict();
	end
endmodule
